// [rtl/t1e1_consts.svh]
// Constants for the T1/E1 line data port multiplexer
`ifndef T1E1_CONSTS_SVH
`define T1E1_CONSTS_SVH

// System clock period and transmit clock loss timeout
`define CLK_PERIOD_NS 10
`define TX_IDLE_NS 2000
`define TX_IDLE_CYCLES (`TX_IDLE_NS / `CLK_PERIOD_NS)
`define IDLE_CNT_W 8

// Transmit clock edges seen before the link side leaves reset
`define LINK_RST_EDGES 8
`define LINK_RST_W 4

// Pins sampled in the system clock domain
`define PIN_COUNT 4
`define PIN_MCLK 0
`define PIN_TRANSMIT_CLOCK 1
`define PIN_POS 2
`define PIN_NEG 3

// Test pattern generator, x^20 + x^17 + 1
`define PRBS_W 20
`define PRBS_TAP_A 19
`define PRBS_TAP_B 16
`define PRBS_SEED 20'h00001

`endif

// [rtl/t1e1_line_data_port_mux.sv]
// Mode dependent transmit and receive data pin logic of a T1/E1 transceiver
`timescale 1ns/10ps

// Function
// - On signal loss the receive clock output follows the master clock.
// - Bipolar inputs sampled on falling transmit clock, else master clock.
// - Unipolar data input sampled on falling transmit clock, else master clock.
// - In QRSS mode each rising error-insert input adds one logic error.
// - Inserted error follows the active loopback data path.
// - Error-insert input sampled on falling transmit or master clock.
// - Each rising violation-insert input inserts exactly one violation.
// - In QRSS mode violations go into the internal test pattern.
// - Pins remap per mode: bipolar, unipolar, QRSS functions.
// - Unipolar modes flag each received violation, NRZ, rising clock.
// - Bipolar modes output received positive and negative pulses, NRZ.
module t1e1_line_data_port_mux
  import t1e1_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic master_clock,
  input wire logic transmit_clock,
  input wire logic tx_positive_in,
  input wire logic tx_negative_in,
  input wire logic unipolar_select,
  input wire logic qrss_select,
  input wire logic loopback_local,
  input wire logic signal_lost,
  input wire logic line_rx_clock,
  input wire logic line_rx_pos,
  input wire logic line_rx_neg,
  input wire logic line_rx_valid,
  output logic tx_line_pos,
  output logic tx_line_neg,
  output logic tx_bit_valid,
  output logic tx_error_inserted,
  output logic tx_violation_inserted,
  output logic tx_clock_present,
  output logic rx_positive_out,
  output logic rx_negative_out,
  output logic rx_clock_out
);

  // ---- Link domain, falling edge of the transmit clock ----
  logic link_rst_meta;
  logic link_rst_n_reg;
  logic link_pos_reg;
  logic link_neg_reg;
  logic link_pos_rise_reg;
  logic link_neg_rise_reg;
  logic link_toggle_reg;
  logic link_rst_req_reg;

  // Stretched reset request brought into the link domain
  always_ff @(negedge transmit_clock) begin
    link_rst_meta <= link_rst_req_reg;
    link_rst_n_reg <= link_rst_meta;
  end

  // Pin capture with rising-request detection per sample
  always_ff @(negedge transmit_clock) begin
    if (!link_rst_n_reg) begin
      link_pos_reg <= 1'b0;
      link_neg_reg <= 1'b0;
      link_pos_rise_reg <= 1'b0;
      link_neg_rise_reg <= 1'b0;
      link_toggle_reg <= 1'b0;
    end else begin
      link_pos_rise_reg <= tx_positive_in & ~link_pos_reg;
      link_neg_rise_reg <= tx_negative_in & ~link_neg_reg;
      link_pos_reg <= tx_positive_in;
      link_neg_reg <= tx_negative_in;
      link_toggle_reg <= ~link_toggle_reg; // Marks a new sample
    end
  end

  // ---- System domain: pin synchronisers ----
  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0] pin_s1_reg;
  logic [`PIN_COUNT-1:0] pin_s2_reg;
  logic [`PIN_COUNT-1:0] pin_s3_reg;
  logic [`PIN_COUNT-1:0] pin_filt_reg;
  logic [`PIN_COUNT-1:0] pin_prev_reg;

  assign pin_raw = {tx_negative_in, tx_positive_in, transmit_clock,
                    master_clock};

  // Three-stage synchroniser chain
  always_ff @(posedge clock) begin
    pin_s1_reg <= pin_raw;
    pin_s2_reg <= pin_s1_reg;
    pin_s3_reg <= pin_s2_reg;
  end

  // A pin change counts once stages two and three agree
  for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin_filt
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pin_filt_reg[i] <= 1'b0;
      end else if (pin_s2_reg[i] == pin_s3_reg[i]) begin
        pin_filt_reg[i] <= pin_s3_reg[i];
      end
    end
  end

  // Previous filtered levels for edge detection
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_prev_reg <= '0;
    end else begin
      pin_prev_reg <= pin_filt_reg;
    end
  end

  logic mclk_fall;
  logic transmit_clock_edge;
  assign mclk_fall = pin_prev_reg[`PIN_MCLK] & ~pin_filt_reg[`PIN_MCLK];
  assign transmit_clock_edge = pin_prev_reg[`PIN_TRANSMIT_CLOCK] ^ pin_filt_reg[`PIN_TRANSMIT_CLOCK];

  // Link reset request stays low until the transmit clock has toggled a
  // few times, so a short system reset still resets the slow link side
  logic [`LINK_RST_W-1:0] link_rst_cnt_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link_rst_cnt_reg <= '0;
      link_rst_req_reg <= 1'b0;
    end else begin
      if (transmit_clock_edge &&
          link_rst_cnt_reg != `LINK_RST_W'(`LINK_RST_EDGES)) begin
        link_rst_cnt_reg <= link_rst_cnt_reg + `LINK_RST_W'(1);
      end
      link_rst_req_reg <=
        (link_rst_cnt_reg == `LINK_RST_W'(`LINK_RST_EDGES));
    end
  end

  // ---- Transmit clock activity detector ----
  logic [`IDLE_CNT_W-1:0] idle_cnt_reg;
  logic tx_active_reg;
  localparam logic [`IDLE_CNT_W-1:0] IdleMax =
    `IDLE_CNT_W'(`TX_IDLE_CYCLES);

  // Counts cycles since the last transmit clock edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idle_cnt_reg <= '0;
    end else if (transmit_clock_edge) begin
      idle_cnt_reg <= '0;
    end else if (idle_cnt_reg != IdleMax) begin
      idle_cnt_reg <= idle_cnt_reg + `IDLE_CNT_W'(1);
    end
  end

  // Falls back to the master clock after the idle timeout
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_active_reg <= 1'b0;
    end else if (transmit_clock_edge) begin
      tx_active_reg <= 1'b1;
    end else if (idle_cnt_reg == IdleMax) begin
      tx_active_reg <= 1'b0;
    end
  end

  // ---- Link sample crossing, toggle through three flops ----
  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;
  logic tog_filt_reg;
  logic tog_prev_reg;
  logic link_event;

  always_ff @(posedge clock) begin
    tog_s1_reg <= link_toggle_reg;
    tog_s2_reg <= tog_s1_reg;
    tog_s3_reg <= tog_s2_reg;
  end

  // Filtered toggle and its previous value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tog_filt_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      if (tog_s2_reg == tog_s3_reg) begin
        tog_filt_reg <= tog_s3_reg;
      end
      tog_prev_reg <= tog_filt_reg;
    end
  end

  assign link_event = tog_filt_reg ^ tog_prev_reg;

  // ---- Master clock sampling path ----
  logic mst_pos_prev_reg;
  logic mst_neg_prev_reg;

  // Previous samples taken on falling master clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mst_pos_prev_reg <= 1'b0;
      mst_neg_prev_reg <= 1'b0;
    end else if (mclk_fall) begin
      mst_pos_prev_reg <= pin_filt_reg[`PIN_POS];
      mst_neg_prev_reg <= pin_filt_reg[`PIN_NEG];
    end
  end

  // Sample source chosen by transmit clock presence
  logic bit_strobe;
  logic samp_pos;
  logic samp_neg;
  logic rise_pos;
  logic rise_neg;
  always_comb begin
    if (tx_active_reg) begin
      bit_strobe = link_event;
      samp_pos = link_pos_reg;
      samp_neg = link_neg_reg;
      rise_pos = link_pos_rise_reg;
      rise_neg = link_neg_rise_reg;
    end else begin
      bit_strobe = mclk_fall;
      samp_pos = pin_filt_reg[`PIN_POS];
      samp_neg = pin_filt_reg[`PIN_NEG];
      rise_pos = pin_filt_reg[`PIN_POS] & ~mst_pos_prev_reg;
      rise_neg = pin_filt_reg[`PIN_NEG] & ~mst_neg_prev_reg;
    end
  end

  // ---- Mode decode ----
  port_mode_t mode_reg;
  port_mode_t mode_next;
  always_comb begin
    case ({qrss_select, unipolar_select})
      2'h0: mode_next = MODE_BIPOLAR;
      2'h1: mode_next = MODE_UNIPOLAR;
      2'h2: mode_next = MODE_QRSS_BI;
      default: mode_next = MODE_QRSS_UNI;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg <= MODE_BIPOLAR;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ---- Transmit bit builder ----
  prbs_t prbs_reg;
  logic last_pol_reg;
  logic mark_c;
  logic viol_c;
  logic err_c;
  logic ami_c;
  logic pol_c;

  // Pin meaning per mode, AMI coding with optional violation
  always_comb begin
    mark_c = 1'b0;
    viol_c = 1'b0;
    err_c = 1'b0;
    ami_c = 1'b1;
    case (mode_reg)
      MODE_BIPOLAR: ami_c = 1'b0;
      MODE_UNIPOLAR: begin
        mark_c = samp_pos;
        viol_c = rise_neg;
      end
      MODE_QRSS_BI, MODE_QRSS_UNI: begin
        err_c = rise_pos;
        mark_c = prbs_reg[`PRBS_W-1] ^ rise_pos;
        viol_c = rise_neg;
      end
      default: ami_c = 1'b0;
    endcase
    pol_c = viol_c ? last_pol_reg : ~last_pol_reg;
  end

  logic qrss_mode;
  assign qrss_mode = (mode_reg == MODE_QRSS_BI) ||
                     (mode_reg == MODE_QRSS_UNI);

  // Pattern generator steps once per transmitted bit in the QRSS modes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prbs_reg <= `PRBS_SEED;
    end else if (bit_strobe && qrss_mode) begin
      prbs_reg <= {prbs_reg[`PRBS_W-2:0],
                   prbs_reg[`PRBS_TAP_A] ^ prbs_reg[`PRBS_TAP_B]};
    end
  end

  logic tx_pos_reg;
  logic tx_neg_reg;
  logic tx_valid_reg;
  logic tx_err_reg;
  logic tx_viol_reg;

  // Line symbol registers and one-cycle insert flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_pos_reg <= 1'b0;
      tx_neg_reg <= 1'b0;
      last_pol_reg <= 1'b0;
      tx_valid_reg <= 1'b0;
      tx_err_reg <= 1'b0;
      tx_viol_reg <= 1'b0;
    end else begin
      tx_valid_reg <= bit_strobe;
      tx_err_reg <= bit_strobe & err_c;
      tx_viol_reg <= bit_strobe & viol_c;
      if (bit_strobe) begin
        if (!ami_c) begin
          tx_pos_reg <= samp_pos;
          tx_neg_reg <= samp_neg;
        end else if (mark_c || viol_c) begin
          tx_pos_reg <= pol_c;
          tx_neg_reg <= ~pol_c;
          last_pol_reg <= pol_c;
        end else begin
          tx_pos_reg <= 1'b0;
          tx_neg_reg <= 1'b0;
        end
      end
    end
  end

  // ---- Receive side ----
  logic src_pos;
  logic src_neg;
  logic src_valid;
  logic rx_mark;
  logic rx_violation_flag;
  logic rx_last_pol_reg;
  logic rx_pos_reg;
  logic rx_neg_reg;
  logic rx_clk_reg;

  // Local loopback carries transmitted symbols, errors included
  assign src_pos = loopback_local ? tx_pos_reg : line_rx_pos;
  assign src_neg = loopback_local ? tx_neg_reg : line_rx_neg;
  assign src_valid = loopback_local ? tx_valid_reg : line_rx_valid;
  assign rx_mark = src_pos | src_neg;
  assign rx_violation_flag = rx_mark && (src_pos == rx_last_pol_reg);

  // Receive outputs per mode, held between symbols
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_pos_reg <= 1'b0;
      rx_neg_reg <= 1'b0;
      rx_last_pol_reg <= 1'b0;
    end else if (src_valid) begin
      if (rx_mark) begin
        rx_last_pol_reg <= src_pos;
      end
      if (mode_reg == MODE_BIPOLAR || mode_reg == MODE_QRSS_BI) begin
        rx_pos_reg <= src_pos;
        rx_neg_reg <= src_neg;
      end else begin
        rx_pos_reg <= rx_mark;
        rx_neg_reg <= rx_violation_flag;
      end
    end
  end

  // Recovered clock, replaced by master clock on signal loss
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_clk_reg <= 1'b0;
    end else if (signal_lost) begin
      rx_clk_reg <= pin_filt_reg[`PIN_MCLK];
    end else begin
      rx_clk_reg <= line_rx_clock;
    end
  end

  // Outputs straight from registers
  assign tx_line_pos = tx_pos_reg;
  assign tx_line_neg = tx_neg_reg;
  assign tx_bit_valid = tx_valid_reg;
  assign tx_error_inserted = tx_err_reg;
  assign tx_violation_inserted = tx_viol_reg;
  assign tx_clock_present = tx_active_reg;
  assign rx_positive_out = rx_pos_reg;
  assign rx_negative_out = rx_neg_reg;
  assign rx_clock_out = rx_clk_reg;

  // ---- Checks ----
  sequence qrss_err_req_s;
    bit_strobe && qrss_mode && rise_pos;
  endsequence

  sequence viol_req_s;
    bit_strobe && (mode_reg != MODE_BIPOLAR) && rise_neg;
  endsequence

  err_insert_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    qrss_err_req_s |=> tx_error_inserted && tx_bit_valid)
    else $error("error insert request not honoured");

  viol_insert_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    viol_req_s |=> tx_violation_inserted ##1 !tx_violation_inserted)
    else $error("violation insert not single");

  viol_polarity_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    viol_req_s |=> tx_line_pos == $past(last_pol_reg)
                   && tx_line_pos != tx_line_neg)
    else $error("violation polarity wrong");

  bipolar_pass_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bit_strobe && mode_reg == MODE_BIPOLAR |=>
      tx_line_pos == $past(samp_pos) && !tx_violation_inserted)
    else $error("bipolar data not passed");

  fallback_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !tx_clock_present && mclk_fall |=> tx_bit_valid)
    else $error("master clock fallback missing");

  transmit_clock_loss_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    tx_active_reg && idle_cnt_reg == IdleMax && !transmit_clock_edge
      |=> !tx_clock_present)
    else $error("transmit clock loss not seen");

  los_clock_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    signal_lost ##1 signal_lost |->
      rx_clock_out == $past(pin_filt_reg[`PIN_MCLK]))
    else $error("receive clock not from master");

  rx_unipolar_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    src_valid && mode_reg == MODE_UNIPOLAR |=>
      rx_negative_out == $past(rx_violation_flag)
      && rx_positive_out == $past(rx_mark))
    else $error("unipolar receive outputs wrong");

  loop_err_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    loopback_local && tx_bit_valid && mode_reg == MODE_QRSS_BI
      |=> rx_positive_out == $past(tx_line_pos))
    else $error("error not carried by loopback");

endmodule

// [rtl/t1e1_pkg.sv]
// Types shared by the T1/E1 line data port multiplexer
package t1e1_pkg;
  `include "t1e1_consts.svh"

  // Pin mapping modes, one-hot
  typedef enum logic [3:0] {
    MODE_BIPOLAR = 4'h1,
    MODE_UNIPOLAR = 4'h2,
    MODE_QRSS_BI = 4'h4,
    MODE_QRSS_UNI = 4'h8
  } port_mode_t;

  typedef logic [`PRBS_W-1:0] prbs_t;
endpackage

// [tb/framer_model.sv]
// Framer side model: master clock, gated transmit clock and transmit pins
`timescale 1ns/10ps
module framer_model (
  input wire logic run,
  input wire logic pos_req,
  input wire logic neg_req,
  output logic master_clock,
  output logic transmit_clock,
  output logic tx_positive_in,
  output logic tx_negative_in
);
  // Free running master clock at the T1 rate
  initial begin
    master_clock = 1'b0;
    forever #324 master_clock = ~master_clock;
  end

  // Transmit clock toggles only while traffic runs, otherwise stands low
  initial begin
    transmit_clock = 1'b0;
    #3;
    forever begin
      #40;
      transmit_clock = run ? ~transmit_clock : 1'b0;
    end
  end

  // Pins launched on the rising edge so the falling sample sees them settled
  initial begin
    tx_positive_in = 1'b0;
    tx_negative_in = 1'b0;
  end
  always @(posedge transmit_clock) begin
    tx_positive_in <= pos_req;
    tx_negative_in <= neg_req;
  end
endmodule

// [tb/t1e1_line_data_port_mux_tb_top.sv]
// Self-checking bench for the T1/E1 line data port multiplexer
`timescale 1ns/10ps
module t1e1_line_data_port_mux_tb_top;
  logic clock, rst_n, run, pos_req, neg_req, unipolar_select, qrss_select;
  logic loopback_local, signal_lost, line_rx_clock, line_rx_pos;
  logic line_rx_neg, line_rx_valid, master_clock, transmit_clock;
  logic tx_positive_in, tx_negative_in, tx_line_pos, tx_line_neg;
  logic tx_bit_valid, tx_error_inserted, tx_violation_inserted;
  logic tx_clock_present, rx_positive_out, rx_negative_out, rx_clock_out;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_err_ins = 0;
  int n_vio_ins = 0;
  logic [31:0] seed = 32'h0000003c;

  framer_model framer_model_inst (.run(run), .pos_req(pos_req),
    .neg_req(neg_req), .master_clock(master_clock),
    .transmit_clock(transmit_clock), .tx_positive_in(tx_positive_in),
    .tx_negative_in(tx_negative_in));

  t1e1_line_data_port_mux t1e1_line_data_port_mux_inst (.clock(clock),
    .rst_n(rst_n), .master_clock(master_clock),
    .transmit_clock(transmit_clock), .tx_positive_in(tx_positive_in),
    .tx_negative_in(tx_negative_in), .unipolar_select(unipolar_select),
    .qrss_select(qrss_select), .loopback_local(loopback_local),
    .signal_lost(signal_lost), .line_rx_clock(line_rx_clock),
    .line_rx_pos(line_rx_pos), .line_rx_neg(line_rx_neg),
    .line_rx_valid(line_rx_valid), .tx_line_pos(tx_line_pos),
    .tx_line_neg(tx_line_neg), .tx_bit_valid(tx_bit_valid),
    .tx_error_inserted(tx_error_inserted),
    .tx_violation_inserted(tx_violation_inserted),
    .tx_clock_present(tx_clock_present),
    .rx_positive_out(rx_positive_out), .rx_negative_out(rx_negative_out),
    .rx_clock_out(rx_clock_out));

  // System clock, 100 MHz
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Insert pulse counters and hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (tx_error_inserted === 1'b1) n_err_ins <= n_err_ins + 1;
    if (tx_violation_inserted === 1'b1) n_vio_ins <= n_vio_ins + 1;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // A mark repeating the previous polarity is a violation
  function automatic logic vio_exp(input logic last_pos, input logic cur_pos);
    return last_pos == cur_pos;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits for the next transmit bit, looked at while its pulse stands
  task automatic wait_valid();
    for (int i = 0; i < 200; i++) begin
      @(negedge clock);
      if (tx_bit_valid === 1'b1) break;
    end
  endtask

  task automatic rx_sym(input logic p, input logic n);
    line_rx_pos = p;
    line_rx_neg = n;
    line_rx_valid = 1'b1;
    @(negedge clock);
    line_rx_valid = 1'b0;
    @(negedge clock);
  endtask

  // Raises one insert pin, counts pulses, then holds it high for more
  task automatic ins_test(input logic err, input int exp_n);
    int e0;
    int v0;
    e0 = n_err_ins;
    v0 = n_vio_ins;
    if (err) pos_req = 1'b1;
    else neg_req = 1'b1;
    repeat (60) @(negedge clock);
    chk(8'(err ? n_err_ins - e0 : n_vio_ins - v0), 8'(exp_n));
    repeat (60) @(negedge clock);
    chk(8'(err ? n_err_ins - e0 : n_vio_ins - v0), 8'(exp_n));
    pos_req = 1'b0;
    neg_req = 1'b0;
    repeat (30) @(negedge clock);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    int seen;
    logic [1:0] lp;
    {rst_n, pos_req, neg_req, unipolar_select, qrss_select} = 5'h00;
    {loopback_local, signal_lost, line_rx_clock} = 3'h0;
    {line_rx_pos, line_rx_neg, line_rx_valid} = 3'h0;
    run = 1'b1;
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk({tx_line_pos, tx_line_neg, tx_bit_valid, tx_clock_present,
      rx_positive_out, rx_negative_out, rx_clock_out}, 8'h00);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      seed = xorshift(seed);
      pos_req = seed[0];
      neg_req = seed[1] & ~seed[0];
      repeat (20) @(negedge clock);
      wait_valid();
      chk({tx_line_pos, tx_line_neg}, {pos_req, neg_req});
    end
    pos_req = 1'b0;
    neg_req = 1'b0;
    $display("test bipolar transmit done");
    for (int k = 0; k < 8; k++) begin
      seed = xorshift(seed);
      rx_sym(seed[0], seed[1] & ~seed[0]);
      chk({rx_positive_out, rx_negative_out},
        {seed[0], seed[1] & ~seed[0]});
    end
    unipolar_select = 1'b1;
    rx_sym(1'b1, 1'b0);
    rx_sym(1'b1, 1'b0);
    chk({rx_positive_out, rx_negative_out}, {1'b1, vio_exp(1, 1)});
    rx_sym(1'b0, 1'b1);
    chk({rx_positive_out, rx_negative_out}, {1'b1, vio_exp(1, 0)});
    $display("test receive done");
    repeat (30) @(negedge clock);
    // Unipolar marks alternate polarity on successive bits
    pos_req = 1'b1;
    repeat (20) @(negedge clock);
    wait_valid();
    lp = {tx_line_pos, tx_line_neg};
    chk(8'(lp[1] ^ lp[0]), 8'h01);
    wait_valid();
    chk({tx_line_pos, tx_line_neg}, {lp[0], lp[1]});
    pos_req = 1'b0;
    ins_test(1'b0, 1);
    qrss_select = 1'b1;
    unipolar_select = 1'b0;
    repeat (30) @(negedge clock);
    // Loopback returns each transmitted symbol, inserted errors included
    loopback_local = 1'b1;
    pos_req = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wait_valid();
      lp = {tx_line_pos, tx_line_neg};
      @(negedge clock);
      chk({rx_positive_out, rx_negative_out}, lp);
    end
    loopback_local = 1'b0;
    pos_req = 1'b0;
    repeat (30) @(negedge clock);
    ins_test(1'b1, 1);
    unipolar_select = 1'b1;
    ins_test(1'b0, 1);
    qrss_select = 1'b0;
    unipolar_select = 1'b0;
    ins_test(1'b1, 0);
    $display("test inserts done");
    run = 1'b0;
    repeat (250) @(negedge clock);
    chk(tx_clock_present, 1'b0);
    wait_valid();
    chk(tx_bit_valid, 1'b1);
    run = 1'b1;
    repeat (60) @(negedge clock);
    chk(tx_clock_present, 1'b1);
    $display("test clock fallback done");
    for (int k = 0; k < 8; k++) begin
      seed = xorshift(seed);
      line_rx_clock = seed[0];
      @(negedge clock);
      chk(rx_clock_out, seed[0]);
    end
    signal_lost = 1'b1;
    line_rx_clock = 1'b1;
    seen = 0;
    repeat (100) begin
      @(negedge clock);
      if (rx_clock_out === 1'b0) seen = 1;
    end
    chk(8'(seen), 8'h01);
    $display("test receive clock done");
    summarize();
  end
endmodule
